// ==== core/lp_ctrl_defines.svh ====
// Register offsets, field layout, reset values and fixed counts of the low-power pin control block
`ifndef LP_CTRL_DEFINES_SVH
`define LP_CTRL_DEFINES_SVH

`define OFF_WAKE_LEVEL      12'h000
`define OFF_WAKE_ENABLE     12'h004
`define OFF_CRYSTAL         12'h008
`define OFF_LP_DIRECTION    12'h00c
`define OFF_LP_OUTPUT       12'h010
`define OFF_LP_DRIVE        12'h014
`define OFF_LP_PULL         12'h018
`define OFF_LP_MODE         12'h01c
`define OFF_WAKE_STATUS     12'h020

`define WAKE_PINS           5
`define LP_PINS             3

`define RST_WAKE_LEVEL      5'h00
`define RST_WAKE_ENABLE     5'h07
`define RST_CRYSTAL         1'h0
`define RST_LP_DIRECTION    3'h7
`define RST_LP_OUTPUT       3'h0
`define RST_LP_DRIVE        3'h0
`define RST_LP_PULL         3'h7
`define RST_LP_MODE         1'h0

`define FAST_XTAL_BIT       0
`define LP_MODE_BIT         0

`endif

// ==== core/lp_ctrl_pkg.sv ====
// Types shared by the low-power pin control block
package lp_ctrl_pkg;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b00,
      APB_SETUP  = 2'b01,
      APB_ACCESS = 2'b10
   } apb_phase_e;

   typedef logic [4:0] wake_vec_t;
   typedef logic [2:0] lp_vec_t;

endpackage : lp_ctrl_pkg

// ==== core/lp_pin_ctrl.sv ====
// Per-pin output and pull resolution for the three sleep-capable pins
`timescale 1ns/1ns
`include "lp_ctrl_defines.svh"

module lp_pin_ctrl
   import lp_ctrl_pkg::*;
(
   // Mode
   input  wire logic    low_power,
   // Settings
   input  wire lp_vec_t wake_en,
   input  wire lp_vec_t direction,
   input  wire lp_vec_t out_value,
   input  wire lp_vec_t drive,
   input  wire lp_vec_t pull,
   // Pad controls
   output lp_vec_t      pad_out,
   output lp_vec_t      pad_oe,
   output lp_vec_t      pad_drive_high,
   output lp_vec_t      pad_pull_en
);

   genvar i;
   generate
      for (i = 0; i < `LP_PINS; i++) begin : g_pin
         // Wake pins must stay inputs, so direction is ignored for them
         assign pad_oe[i]         = low_power & ~wake_en[i] & ~direction[i]; // RULE_04 RULE_11
         assign pad_out[i]        = pad_oe[i] & out_value[i];                 // RULE_05
         assign pad_drive_high[i] = low_power & drive[i];                     // RULE_07
         // Pull stays effective even on wake pins
         assign pad_pull_en[i]    = low_power & pull[i];                      // RULE_08 RULE_11
      end
   endgenerate

endmodule : lp_pin_ctrl

// ==== core/lp_wake_ctrl.sv ====
// APB register bank and wake detection for low-power pin control
`timescale 1ns/1ns
`include "lp_ctrl_defines.svh"

// Overview of operation
// (RULE_01) Five wake-enable bits, bit n lets wake pin n wake the device.
// (RULE_02) Wake-enable field resets to 0x07: first three pins enabled.
// (RULE_03) Bit 0 of crystal register: 0 means 16 MHz, 1 means 32 MHz; reset 0.
// (RULE_04) Three direction bits, 0 output, 1 input, reset all inputs.
// (RULE_05) In low power, output pins drive their written output value; reset 0.
// (RULE_06) Reading the output value returns last written value, not pin level.
// (RULE_07) Three drive bits, 0 low drive, 1 high drive, reset 0.
// (RULE_08) Three pull bits, 0 pull off, 1 pull on, reset all on.
// (RULE_09) Software writes reserved bits with their reset value.
// (RULE_10) Five wake-level bits, 0 wakes on low, 1 on high; reset 0.
// (RULE_11) Wake-enabled sleep pin ignores direction bit; pull still applies.
// (RULE_12) In low power, enabled pin at selected level raises wake request.
module lp_wake_ctrl
   import lp_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Wake pins
   input  wire wake_vec_t   wake_pin_in,
   output logic             wake_request,
   // Crystal indication
   output logic             fast_crystal_select,
   // Sleep-capable pin pads
   output lp_vec_t          lp_pad_out,
   output lp_vec_t          lp_pad_oe,
   output lp_vec_t          lp_pad_drive_high,
   output lp_vec_t          lp_pad_pull_en
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      wake_vec_t   wake_level;
      wake_vec_t   wake_enable;
      logic        fast_xtal;
      lp_vec_t     lp_direction;
      lp_vec_t     lp_output;
      lp_vec_t     lp_drive;
      lp_vec_t     lp_pull;
      logic        lp_mode;
      logic        wake_req;
      wake_vec_t   wake_seen;
      logic [31:0] rdata;
      logic        slverr;
   } state_s;

   state_s state_r;
   state_s state_nxt;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   function automatic logic addr_known(input logic [11:0] a);
      unique case (a)
         `OFF_WAKE_LEVEL, `OFF_WAKE_ENABLE, `OFF_CRYSTAL, `OFF_LP_DIRECTION,
         `OFF_LP_OUTPUT, `OFF_LP_DRIVE, `OFF_LP_PULL, `OFF_LP_MODE,
         `OFF_WAKE_STATUS: addr_known = 1'b1;
         default:          addr_known = 1'b0;
      endcase
   endfunction : addr_known

   function automatic logic [31:0] read_mux(input state_s s, input logic [11:0] a);
      read_mux = 32'h0000_0000;
      unique case (a)
         `OFF_WAKE_LEVEL:   read_mux[4:0] = s.wake_level;
         `OFF_WAKE_ENABLE:  read_mux[4:0] = s.wake_enable;
         `OFF_CRYSTAL:      read_mux[`FAST_XTAL_BIT] = s.fast_xtal;
         `OFF_LP_DIRECTION: read_mux[2:0] = s.lp_direction;
         `OFF_LP_OUTPUT:    read_mux[2:0] = s.lp_output; // RULE_06
         `OFF_LP_DRIVE:     read_mux[2:0] = s.lp_drive;
         `OFF_LP_PULL:      read_mux[2:0] = s.lp_pull;
         `OFF_LP_MODE:      read_mux[`LP_MODE_BIT] = s.lp_mode;
         `OFF_WAKE_STATUS:  read_mux[5:0] = {s.wake_req, s.wake_seen};
         default:           read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   logic      access;
   logic      wr_ok;
   logic      wr_lane0;
   wake_vec_t wake_hit;

   assign access   = psel & penable;
   wire logic known = addr_known(paddr);
   assign wr_ok    = access & pwrite & known;
   // All fields sit in byte lane 0; upper bits are reserved and kept at zero
   assign wr_lane0 = wr_ok & pstrb[0]; // RULE_09

   // -----------------------------------------------------------------
   // Wake detection
   // -----------------------------------------------------------------
   genvar w;
   generate
      for (w = 0; w < `WAKE_PINS; w++) begin : g_wake
         // Level compare: xnor of pin against selected level
         assign wake_hit[w] = state_r.wake_enable[w] &
                              ~(wake_pin_in[w] ^ state_r.wake_level[w]); // RULE_01 RULE_10
      end
   endgenerate

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      if (wr_lane0) begin
         unique case (paddr)
            `OFF_WAKE_LEVEL:   state_nxt.wake_level   = pwdata[4:0];  // RULE_10
            `OFF_WAKE_ENABLE:  state_nxt.wake_enable  = pwdata[4:0];  // RULE_01
            `OFF_CRYSTAL:      state_nxt.fast_xtal    = pwdata[`FAST_XTAL_BIT]; // RULE_03
            `OFF_LP_DIRECTION: state_nxt.lp_direction = pwdata[2:0];  // RULE_04
            `OFF_LP_OUTPUT:    state_nxt.lp_output    = pwdata[2:0];  // RULE_05
            `OFF_LP_DRIVE:     state_nxt.lp_drive     = pwdata[2:0];  // RULE_07
            `OFF_LP_PULL:      state_nxt.lp_pull      = pwdata[2:0];  // RULE_08
            `OFF_LP_MODE:      state_nxt.lp_mode      = pwdata[`LP_MODE_BIT];
            default:           state_nxt.lp_mode      = state_r.lp_mode;
         endcase
      end
      // Wake sticks until software leaves low power; a hit in the same
      // cycle as the exit write still wins
      if (state_r.lp_mode && (|wake_hit)) begin
         state_nxt.wake_req  = 1'b1;                                  // RULE_12
         state_nxt.wake_seen = state_r.wake_seen | wake_hit;
      end else if (!state_nxt.lp_mode) begin
         state_nxt.wake_req  = 1'b0;
      end
      if (wr_lane0 && paddr == `OFF_WAKE_STATUS && !(state_r.lp_mode && |wake_hit)) begin
         state_nxt.wake_seen = state_r.wake_seen & ~pwdata[4:0];
      end
      state_nxt.rdata  = (psel && !penable && !pwrite) ? read_mux(state_r, paddr) : 32'h0;
      state_nxt.slverr = psel & ~penable & ~addr_known(paddr);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r.wake_level   <= `RST_WAKE_LEVEL;   // RULE_10
         state_r.wake_enable  <= `RST_WAKE_ENABLE;  // RULE_02
         state_r.fast_xtal    <= `RST_CRYSTAL;      // RULE_03
         state_r.lp_direction <= `RST_LP_DIRECTION; // RULE_04
         state_r.lp_output    <= `RST_LP_OUTPUT;    // RULE_05
         state_r.lp_drive     <= `RST_LP_DRIVE;     // RULE_07
         state_r.lp_pull      <= `RST_LP_PULL;      // RULE_08
         state_r.lp_mode      <= `RST_LP_MODE;
         state_r.wake_req     <= 1'b0;
         state_r.wake_seen    <= 5'h00;
         state_r.rdata        <= 32'h0000_0000;
         state_r.slverr       <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign pready              = 1'b1;
   assign prdata              = state_r.rdata;
   assign pslverr             = access & state_r.slverr;
   assign wake_request        = state_r.wake_req;
   assign fast_crystal_select = state_r.fast_xtal;

   lp_pin_ctrl u_pins (
      .low_power      (state_r.lp_mode),
      .wake_en        (state_r.wake_enable[2:0]),
      .direction      (state_r.lp_direction),
      .out_value      (state_r.lp_output),
      .drive          (state_r.lp_drive),
      .pull           (state_r.lp_pull),
      .pad_out        (lp_pad_out),
      .pad_oe         (lp_pad_oe),
      .pad_drive_high (lp_pad_drive_high),
      .pad_pull_en    (lp_pad_pull_en)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_wake_rst;
      @(posedge pclk) $rose(presetn) |-> state_r.wake_enable == `RST_WAKE_ENABLE;
   endproperty
   a_wake_rst: assert property (p_wake_rst) else $error("wake enable reset wrong"); // RULE_02

   property p_pull_rst;
      @(posedge pclk) $rose(presetn) |-> lp_pad_pull_en == 3'h0 && state_r.lp_pull == `RST_LP_PULL;
   endproperty
   a_pull_rst: assert property (p_pull_rst) else $error("pull reset wrong"); // RULE_08

   property p_wr_enable;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_WAKE_ENABLE)
         |=> state_r.wake_enable == $past(pwdata[4:0]);
   endproperty
   a_wr_enable: assert property (p_wr_enable) else $error("wake enable write lost"); // RULE_01

   property p_xtal;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_CRYSTAL) |=> fast_crystal_select == $past(pwdata[0]);
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal select wrong"); // RULE_03

   property p_out_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `OFF_LP_OUTPUT)
         |=> prdata[2:0] == $past(state_r.lp_output, 1);
   endproperty
   a_out_read: assert property (p_out_read) else $error("output readback wrong"); // RULE_06

   property p_drive_out;
      @(posedge pclk) disable iff (!presetn)
      lp_pad_oe[0] |-> lp_pad_out[0] == state_r.lp_output[0] && !state_r.lp_direction[0];
   endproperty
   a_drive_out: assert property (p_drive_out) else $error("pad drive wrong"); // RULE_05

   property p_wake_input;
      @(posedge pclk) disable iff (!presetn)
      state_r.wake_enable[1] |-> !lp_pad_oe[1];
   endproperty
   a_wake_input: assert property (p_wake_input) else $error("wake pin driven"); // RULE_11

   property p_wake_req;
      @(posedge pclk) disable iff (!presetn)
      (state_r.lp_mode && wake_pin_in[3] == state_r.wake_level[3] && state_r.wake_enable[3])
         |=> wake_request;
   endproperty
   a_wake_req: assert property (p_wake_req) else $error("wake request missed"); // RULE_12

   property p_level_low;
      @(posedge pclk) disable iff (!presetn)
      (state_r.lp_mode && !state_r.wake_req && state_r.wake_enable == 5'h01
         && state_r.wake_level[0] && !wake_pin_in[0]) |=> !wake_request;
   endproperty
   a_level_low: assert property (p_level_low) else $error("wake on wrong level"); // RULE_10

   property p_strength;
      @(posedge pclk) disable iff (!presetn)
      state_r.lp_mode |-> lp_pad_drive_high == state_r.lp_drive
         && lp_pad_pull_en == state_r.lp_pull;
   endproperty
   a_strength: assert property (p_strength) else $error("drive or pull wrong"); // RULE_07

   // Outside low power the normal pin logic owns the pads
   property p_pad_idle;
      @(posedge pclk) disable iff (!presetn)
      !state_r.lp_mode |-> lp_pad_oe == 3'h0 && lp_pad_out == 3'h0
         && lp_pad_drive_high == 3'h0 && lp_pad_pull_en == 3'h0;
   endproperty
   a_pad_idle: assert property (p_pad_idle) else $error("pads active outside low power");

   // -----------------------------------------------------------------
   // Register write checks
   // -----------------------------------------------------------------
   // A field takes the low bits of the word at the access edge only
   property p_wr_level;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_WAKE_LEVEL)
         |=> state_r.wake_level == $past(pwdata[4:0]);
   endproperty
   a_wr_level: assert property (p_wr_level) else $error("wake level write lost"); // RULE_10

   property p_wr_dir;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_LP_DIRECTION)
         |=> state_r.lp_direction == $past(pwdata[2:0]);
   endproperty
   a_wr_dir: assert property (p_wr_dir) else $error("direction write lost"); // RULE_04

   property p_wr_out;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_LP_OUTPUT)
         |=> state_r.lp_output == $past(pwdata[2:0]);
   endproperty
   a_wr_out: assert property (p_wr_out) else $error("output value write lost"); // RULE_05

   property p_wr_drv;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_LP_DRIVE)
         |=> state_r.lp_drive == $past(pwdata[2:0]);
   endproperty
   a_wr_drv: assert property (p_wr_drv) else $error("drive write lost"); // RULE_07

   property p_wr_pull;
      @(posedge pclk) disable iff (!presetn)
      (wr_lane0 && paddr == `OFF_LP_PULL)
         |=> state_r.lp_pull == $past(pwdata[2:0]);
   endproperty
   a_wr_pull: assert property (p_wr_pull) else $error("pull write lost"); // RULE_08

   // Lane 0 masked: wake enable, crystal, output and direction may not move, or reserved writes could leak in
   property p_strobe_block;
      @(posedge pclk) disable iff (!presetn)
      (access && pwrite && !pstrb[0])
         |=> $stable(state_r.wake_enable) && $stable(state_r.fast_xtal)
            && $stable(state_r.lp_output) && $stable(state_r.lp_direction);
   endproperty
   a_strobe_block: assert property (p_strobe_block) else $error("masked write took effect");

   // -----------------------------------------------------------------
   // Bus and wake checks
   // -----------------------------------------------------------------
   // Decode is registered in setup, so the error relies on a proper setup cycle
   property p_unmapped_err;
      @(posedge pclk) disable iff (!presetn)
      (access && !known) |-> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("missing slave error");

   // Read data stands for the access cycle only
   property p_read_zero;
      @(posedge pclk) disable iff (!presetn)
      access |=> prdata == 32'h0000_0000;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("read data left standing");

   // Wake stays raised for as long as the mode bit is not rewritten
   property p_wake_hold;
      @(posedge pclk) disable iff (!presetn)
      (wake_request && state_r.lp_mode && !(wr_lane0 && paddr == `OFF_LP_MODE))
         |=> wake_request;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped"); // RULE_12

   property p_wake_exit;
      @(posedge pclk) disable iff (!presetn)
      (!state_r.lp_mode && !(wr_lane0 && paddr == `OFF_LP_MODE)) |=> !wake_request;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("stray wake request"); // RULE_12

   property p_wake_off;
      @(posedge pclk) disable iff (!presetn)
      (!state_r.wake_req && state_r.wake_enable == 5'h00) |=> !wake_request;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("disabled pin woke"); // RULE_01

   c_wake:   cover property (@(posedge pclk) $rose(wake_request));
   c_drive:  cover property (@(posedge pclk) lp_pad_oe != 3'h0);
   c_err:    cover property (@(posedge pclk) pslverr);
   c_clear:  cover property (@(posedge pclk) wr_lane0 && paddr == `OFF_WAKE_STATUS);
   c_masked: cover property (@(posedge pclk) access && pwrite && !pstrb[0]);

endmodule : lp_wake_ctrl

// ==== tb/lp_pin_partner.sv ====
// Model of the wake-capable and sleep-capable pins outside the block
`timescale 1ns/1ns

module lp_pin_partner
   import lp_ctrl_pkg::*;
(
   // Clock
   input  wire logic      pclk,
   // Pad controls from the block
   input  wire lp_vec_t   pad_out,
   input  wire lp_vec_t   pad_oe,
   input  wire lp_vec_t   pad_pull_en,
   // Far-side drivers
   input  wire wake_vec_t ext_level,
   input  wire wake_vec_t ext_drive,
   // Resolved pin levels
   output wake_vec_t      pin_level
);
   logic noise = 1'b0;

   // Floating pin wanders each cycle so a missing pull cannot pass by luck
   always @(posedge pclk) begin
      noise <= ~noise;
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (pad_oe[i])
            pin_level[i] = pad_out[i];
         else if (ext_drive[i])
            pin_level[i] = ext_level[i];
         else if (pad_pull_en[i])
            pin_level[i] = 1'b1;
         else
            pin_level[i] = noise;
      end
      // No internal pull on the two upper pins
      for (int i = 3; i < 5; i++) begin
         pin_level[i] = ext_drive[i] ? ext_level[i] : noise;
      end
   end
endmodule : lp_pin_partner

// ==== tb/low_power_wake_and_pin_control_bench.sv ====
// Self-checking bench for the low-power wake and pin control block
`timescale 1ns/1ns

module low_power_wake_and_pin_control_bench
   import lp_ctrl_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        wake_request, fast_crystal_select;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   wake_vec_t   pin_in, lvl, drv;
   lp_vec_t     p_out, p_oe, p_drv, p_pull;
   int          err_total, n_compared, cyc;
   logic [11:0] offs [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
   logic [31:0] rsts [7] = '{32'h00, 32'h07, 32'h00, 32'h07, 32'h00, 32'h00, 32'h07};
   logic [31:0] msks [7] = '{32'h1f, 32'h1f, 32'h01, 32'h07, 32'h07, 32'h07, 32'h07};

   lp_wake_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wake_pin_in(pin_in), .wake_request(wake_request),
      .fast_crystal_select(fast_crystal_select), .lp_pad_out(p_out), .lp_pad_oe(p_oe),
      .lp_pad_drive_high(p_drv), .lp_pad_pull_en(p_pull));

   lp_pin_partner i_pins (.pclk(pclk), .pad_out(p_out), .pad_oe(p_oe),
      .pad_pull_en(p_pull), .ext_level(lvl), .ext_drive(drv), .pin_level(pin_in));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Request held until pready is seen at an edge; data taken there
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), exp, rd);
      chk("pslverr", 32'h0, {31'h0, er});
   endtask : rdchk

   task automatic t_reset;
      for (int i = 0; i < 7; i++) begin
         rdchk(offs[i], rsts[i]);
      end
      rdchk(12'h01c, 32'h0);
      rdchk(12'h020, 32'h0);
      chk("wake_request", 32'h0, {31'h0, wake_request});
      chk("idle pads", 32'h0, {20'h0, p_oe, p_out, p_drv, p_pull});
      $display("t_reset done");
   endtask : t_reset

   task automatic t_rw;
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, offs[i], ~rsts[i] & msks[i]);
         rdchk(offs[i], ~rsts[i] & msks[i]);
      end
      @(posedge pclk);
      chk("fast_crystal_select", 32'h1, {31'h0, fast_crystal_select});
      // Lane 0 masked: the write must be ignored
      pstrb <= 4'he;
      apb(1'b1, 12'h008, 32'h0);
      pstrb <= 4'hf;
      rdchk(12'h008, 32'h1);
      apb(1'b1, 12'h024, 32'h0);
      chk("unmapped write pslverr", 32'h1, {31'h0, er});
      apb(1'b0, 12'h024, 32'h0);
      chk("unmapped read", 32'h0, rd);
      chk("unmapped pslverr", 32'h1, {31'h0, er});
      $display("t_rw done");
   endtask : t_rw

   task automatic t_pads;
      apb(1'b1, 12'h004, 32'h00);
      apb(1'b1, 12'h00c, 32'h02);
      apb(1'b1, 12'h010, 32'h05);
      apb(1'b1, 12'h014, 32'h06);
      apb(1'b1, 12'h018, 32'h03);
      apb(1'b1, 12'h01c, 32'h01);
      @(posedge pclk);
      chk("pad oe", 32'h5, {29'h0, p_oe});
      chk("pad out", 32'h5, {29'h0, p_out & p_oe});
      chk("pad drive", 32'h6, {29'h0, p_drv});
      chk("pad pull", 32'h3, {29'h0, p_pull});
      drv <= 5'h1f;
      lvl <= 5'h00;
      apb(1'b1, 12'h00c, 32'h07);
      rdchk(12'h010, 32'h05);
      apb(1'b1, 12'h00c, 32'h00);
      apb(1'b1, 12'h004, 32'h01);
      @(posedge pclk);
      chk("pad oe wake pin", 32'h6, {29'h0, p_oe});
      chk("pad pull wake pin", 32'h3, {29'h0, p_pull});
      apb(1'b1, 12'h01c, 32'h00);
      @(posedge pclk);
      chk("pads after exit", 32'h0, {20'h0, p_oe, p_out, p_drv, p_pull});
      $display("t_pads done");
   endtask : t_pads

   task automatic t_wake;
      apb(1'b1, 12'h000, 32'h02);
      apb(1'b1, 12'h004, 32'h0a);
      lvl <= 5'h08;
      apb(1'b1, 12'h01c, 32'h01);
      repeat (4) @(posedge pclk);
      chk("wake idle", 32'h0, {31'h0, wake_request});
      lvl <= 5'h0a;
      repeat (2) @(posedge pclk);
      chk("wake raised", 32'h1, {31'h0, wake_request});
      rdchk(12'h020, 32'h22);
      apb(1'b1, 12'h01c, 32'h00);
      repeat (2) @(posedge pclk);
      chk("wake cleared", 32'h0, {31'h0, wake_request});
      // Pin record is sticky until written back with ones
      rdchk(12'h020, 32'h02);
      apb(1'b1, 12'h020, 32'h1f);
      rdchk(12'h020, 32'h00);
      $display("t_wake done");
   endtask : t_wake

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      lvl = 5'h00;
      drv = 5'h00;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rw();
      t_pads();
      t_wake();
      report_and_stop();
   end
endmodule : low_power_wake_and_pin_control_bench
